// File: rtl/mmtu_pkg.sv
// Constants shared by the mode timer unit: register map, field positions,
// reset values and prescaler codes.
// Assumes a 32-bit APB slave with one aligned word per register.
package mmtu_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CLK_RST_CTRL = 8'h00;
	localparam logic [7:0] OFF_CAP_DBG_CTRL = 8'h04;
	localparam logic [7:0] OFF_CAPTURE = 8'h08;
	localparam logic [7:0] OFF_CMP_COMMUT = 8'h0C;
	localparam logic [7:0] OFF_CMP_SAMPLE = 8'h10;
	localparam logic [7:0] OFF_CMP_OVFL = 8'h14;

	// timer_clock_reset_control fields
	localparam int CLK_SEL_LSB = 5;
	localparam int THIRD_RST_EN_BIT = 4;
	localparam int OVL_RST_EN_BIT = 3;
	localparam int SW_RST_BIT = 2;
	localparam int POS_RST_EN_BIT = 1;
	localparam int COUNT_EN_BIT = 0;

	// timer_capture_debug_control fields
	localparam int DEBUG_EN_BIT = 7;
	localparam int OVF_FLAG_BIT = 5;
	localparam int OVL_CAP_EN_BIT = 3;
	localparam int SW_CAP_BIT = 2;
	localparam int POS_CAP_EN_BIT = 1;

	// Reset values and the saturation limit
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;

	// Clock select codes and the matching divider masks
	localparam logic [2:0] SEL_DIV8 = 3'h0;
	localparam logic [2:0] SEL_DIV16 = 3'h2;
	localparam logic [2:0] SEL_DIV32 = 3'h4;
	localparam logic [2:0] SEL_DIV64 = 3'h6;
	localparam logic [2:0] SEL_DIV128 = 3'h1;
	localparam logic [6:0] MASK_DIV8 = 7'h07;
	localparam logic [6:0] MASK_DIV16 = 7'h0F;
	localparam logic [6:0] MASK_DIV32 = 7'h1F;
	localparam logic [6:0] MASK_DIV64 = 7'h3F;
	localparam logic [6:0] MASK_DIV128 = 7'h7F;
	localparam logic [6:0] MASK_NONE = 7'h00;

endpackage : mmtu_pkg

// File: rtl/mmtu_tick_if.sv
// Carrier between the mode timer core and its prescaler.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface mmtu_tick_if;
	logic [2:0] sel;
	logic run;
	logic tick;
	modport ctrl (output sel, output run, input tick);
	modport gen (input sel, input run, output tick);
endinterface : mmtu_tick_if
`default_nettype wire

// File: rtl/mmtu_prescale.sv
// Prescaler for the mode timer: one-cycle count tick at the selected division.
// Assumes the select field only changes while run is low.
`timescale 1ns/1ps
`default_nettype none
module mmtu_prescale (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	mmtu_tick_if.gen tk
);
	import mmtu_pkg::*;

	logic [6:0] div_q;
	logic [6:0] div_d;
	logic [6:0] mask;

	// Code to divider mask; reserved codes never tick
	function automatic logic [6:0] sel_mask(input logic [2:0] sel);
		case (sel)
			SEL_DIV8: sel_mask = MASK_DIV8;
			SEL_DIV16: sel_mask = MASK_DIV16;
			SEL_DIV32: sel_mask = MASK_DIV32;
			SEL_DIV64: sel_mask = MASK_DIV64;
			SEL_DIV128: sel_mask = MASK_DIV128;
			default: sel_mask = MASK_NONE;
		endcase
	endfunction : sel_mask

	// Divider restarts while stopped so the first tick comes a full period in
	always_comb begin
		mask = sel_mask(tk.sel);
		div_d = tk.run ? 7'(div_q + 7'h01) : 7'h00;
		tk.tick = tk.run && (mask != MASK_NONE) && ((div_q & mask) == mask); // RULE_20 RULE_21
	end

	// Divider state
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_q <= 7'h00;
		end else begin
			div_q <= div_d;
		end
	end

	a_tick_reserved: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(sel_mask(tk.sel) == MASK_NONE) |-> !tk.tick) else $error("tick on reserved code"); // RULE_21
	// A stop restarts the divider from zero, so it abandons the spacing check
	a_tick_div8: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i || !tk.run)
		(tk.tick && tk.sel == SEL_DIV8 && $stable(tk.sel)) |=> !tk.tick [*7] ##1 (tk.tick || !tk.run))
		else $error("divide by 8 spacing wrong"); // RULE_21

endmodule : mmtu_prescale
`default_nettype wire

// File: rtl/mmtu_top.sv
// Mode timer unit: 16-bit up counter with restart sources, saturation,
// three one-shot compares, capture register and debug pin, on an APB slave.
// Assumes position_detect_irq_i is a one-cycle pulse on sys_clk_i and the
// overload signal comes asynchronously from a pin.
// Notes on behaviour
// RULE_01: Counter counts up and clears on position detection events when enabled.
// RULE_02: Three compare interrupt outputs derive from the counter value.
// RULE_03: Counter saturates at FFFF and sets readable overflow flag bit 5.
// RULE_04: Third-timer reset enable bit 4 restarts counter on third compare.
// RULE_05: Overload reset enable bit 3 restarts counter on overload assertion.
// RULE_06: Writing 1 to bit 2 restarts counter; write-only, zero ignored.
// RULE_07: Position reset enable bit 1 restarts counter on position event.
// RULE_08: Enable bit 0 starts counting; compares loaded beforehand by software. The code disarms a compare written while bit 0 is clear one cycle later.
// RULE_09: Clearing enable cancels all armed compares until rewritten.
// RULE_10: Compares interrupt only while the counter is enabled.
// RULE_11: First compare fires on greater-or-equal; others on exact match.
// RULE_12: Compares disarm after firing and whenever the counter restarts.
// RULE_13: Any compare write re-arms it, even with an unchanged value.
// RULE_14: Writing 1 to capture bit 2 copies the count to capture.
// RULE_15: Overload capture enable bit 3 captures count on overload assertion.
// RULE_16: Position capture enable bit 1 captures count on position events.
// RULE_17: Each capture overwrites the previous captured value.
// RULE_18: Capture register readable, giving interval between position events.
// RULE_19: Debug enable bit 7 drives a pin from the interrupt signals.
// RULE_20: Clock select bits 7 to 5 choose the prescaled count clock.
// RULE_21: Codes give divide by 8,16,32,64,128; other codes reserved.
// RULE_22: Software changes clock select only while counting is disabled.
// RULE_23: Software avoids read-modify-write on both control registers.
// RULE_24: Capture uses the count before a simultaneous restart clears it.
`timescale 1ns/1ps
`default_nettype none
module mmtu_top (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic position_detect_irq_i,
	input wire logic overload_protect_signal_i,
	output logic [2:0] compare_timer_irq_o,
	output logic debug_pin_o,
	output logic debug_pin_oe_o
);
	import mmtu_pkg::*;

	mmtu_tick_if tk ();

	logic [7:0] ctrl_a_q, ctrl_a_d;
	logic [7:0] ctrl_b_q, ctrl_b_d;
	logic [15:0] count_q, count_d;
	logic [15:0] capture_q, capture_d;
	logic [15:0] cmp_q [3];
	logic [15:0] cmp_d [3];
	logic [2:0] armed_q, armed_d;
	logic [2:0] irq_q, irq_d;
	logic ovf_q, ovf_d;
	logic debug_q, debug_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] ovl_sync_q;
	logic ovl_prev_q;
	logic ovl_rise;
	logic wr_en, setup;
	logic [2:0] cmp_wr;
	logic [2:0] fire;
	logic sw_rst, sw_cap, timer_rst, cap_ev;
	logic run;

	// Decode of the six mapped word offsets
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == OFF_CLK_RST_CTRL) || (a == OFF_CAP_DBG_CTRL) ||
			(a == OFF_CAPTURE) || (a == OFF_CMP_COMMUT) ||
			(a == OFF_CMP_SAMPLE) || (a == OFF_CMP_OVFL);
	endfunction : addr_mapped

	// Overload pin passes two flops; the edge detector reads only the second
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ovl_sync_q <= 2'h0;
			ovl_prev_q <= 1'b0;
		end else begin
			ovl_sync_q <= {ovl_sync_q[0], overload_protect_signal_i};
			ovl_prev_q <= ovl_sync_q[1];
		end
	end
	assign ovl_rise = ovl_sync_q[1] && !ovl_prev_q;

	// APB strobes: zero wait states, unmapped offsets answer with an error
	assign setup = psel_i && !penable_i;
	assign wr_en = psel_i && penable_i && pwrite_i && addr_mapped(paddr_i);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_mapped(paddr_i);
	assign prdata_o = rdata_q;
	assign cmp_wr[0] = wr_en && (paddr_i == OFF_CMP_COMMUT);
	assign cmp_wr[1] = wr_en && (paddr_i == OFF_CMP_SAMPLE);
	assign cmp_wr[2] = wr_en && (paddr_i == OFF_CMP_OVFL);

	// Write-only strobes exist only during the write; zero written does nothing
	assign sw_rst = wr_en && (paddr_i == OFF_CLK_RST_CTRL) && pwdata_i[SW_RST_BIT]; // RULE_06
	assign sw_cap = wr_en && (paddr_i == OFF_CAP_DBG_CTRL) && pwdata_i[SW_CAP_BIT]; // RULE_14

	// Control registers; strobe bits are never stored so they read as zero
	always_comb begin
		ctrl_a_d = ctrl_a_q;
		ctrl_b_d = ctrl_b_q;
		if (wr_en && paddr_i == OFF_CLK_RST_CTRL) begin
			ctrl_a_d = pwdata_i[7:0];
			ctrl_a_d[SW_RST_BIT] = 1'b0;
		end
		if (wr_en && paddr_i == OFF_CAP_DBG_CTRL) begin
			ctrl_b_d = 8'h00;
			ctrl_b_d[DEBUG_EN_BIT] = pwdata_i[DEBUG_EN_BIT];
			ctrl_b_d[OVL_CAP_EN_BIT] = pwdata_i[OVL_CAP_EN_BIT];
			ctrl_b_d[POS_CAP_EN_BIT] = pwdata_i[POS_CAP_EN_BIT];
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_a_q <= CTRL_RESET;
			ctrl_b_q <= CTRL_RESET;
		end else begin
			ctrl_a_q <= ctrl_a_d;
			ctrl_b_q <= ctrl_b_d;
		end
	end

	// Prescaler hookup; select is a plain field, so glitches on a live
	// change are the reason it must only move while stopped
	assign run = ctrl_a_q[COUNT_EN_BIT]; // RULE_08
	assign tk.run = run;
	assign tk.sel = ctrl_a_q[CLK_SEL_LSB +: 3]; // RULE_20

	mmtu_prescale u_prescale (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.tk(tk)
	);

	// Compare matches: first by magnitude so a late write still fires
	always_comb begin
		fire[0] = run && armed_q[0] && (count_q >= cmp_q[0]); // RULE_10 RULE_11
		fire[1] = run && armed_q[1] && (count_q == cmp_q[1]); // RULE_11
		fire[2] = run && armed_q[2] && (count_q == cmp_q[2]); // RULE_11
	end

	// Restart sources; all but the software restart gated by an enable
	assign timer_rst = sw_rst ||
		(position_detect_irq_i && ctrl_a_q[POS_RST_EN_BIT]) || // RULE_01 RULE_07
		(fire[2] && ctrl_a_q[THIRD_RST_EN_BIT]) || // RULE_04
		(ovl_rise && ctrl_a_q[OVL_RST_EN_BIT]); // RULE_05

	// Counter with saturation; overflow flag is sticky until a restart,
	// and a saturation in the restart cycle cannot occur since count goes to zero
	always_comb begin
		count_d = count_q;
		ovf_d = ovf_q;
		if (timer_rst) begin
			count_d = WORD_RESET; // RULE_01
			ovf_d = 1'b0;
		end else if (run && tk.tick) begin
			if (count_q == COUNT_MAX) begin
				ovf_d = 1'b1; // RULE_03
			end else begin
				count_d = 16'(count_q + 16'h0001);
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_q <= WORD_RESET;
			ovf_q <= 1'b0;
		end else begin
			count_q <= count_d;
			ovf_q <= ovf_d;
		end
	end

	// Capture takes the pre-restart count, so it holds the whole interval
	assign cap_ev = sw_cap ||
		(ovl_rise && ctrl_b_q[OVL_CAP_EN_BIT]) || // RULE_15
		(position_detect_irq_i && ctrl_b_q[POS_CAP_EN_BIT]); // RULE_16

	always_comb begin
		capture_d = cap_ev ? count_q : capture_q; // RULE_17 RULE_24
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			capture_q <= WORD_RESET;
		end else begin
			capture_q <= capture_d;
		end
	end

	// Compare registers and arming; a write re-arms even over a restart
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			cmp_d[i] = cmp_wr[i] ? pwdata_i[15:0] : cmp_q[i];
			if (cmp_wr[i]) begin
				armed_d[i] = 1'b1; // RULE_13
			end else if (fire[i] || timer_rst || !run) begin
				armed_d[i] = 1'b0; // RULE_09 RULE_12
			end else begin
				armed_d[i] = armed_q[i];
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 3; i++) begin
				cmp_q[i] <= WORD_RESET;
			end
			armed_q <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				cmp_q[i] <= cmp_d[i];
			end
			armed_q <= armed_d;
		end
	end

	// Interrupt pulses and debug pin, both one cycle after the match
	always_comb begin
		irq_d = fire; // RULE_02
		debug_d = ctrl_b_q[DEBUG_EN_BIT] && (|fire); // RULE_19
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_q <= 3'h0;
			debug_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
			debug_q <= debug_d;
		end
	end
	assign compare_timer_irq_o = irq_q;
	assign debug_pin_o = debug_q;
	assign debug_pin_oe_o = ctrl_b_q[DEBUG_EN_BIT]; // RULE_19

	// Read data is latched in the setup cycle for zero-wait access
	always_comb begin
		rdata_d = rdata_q;
		if (setup) begin
			case (paddr_i)
				OFF_CLK_RST_CTRL: rdata_d = {24'h000000, ctrl_a_q};
				OFF_CAP_DBG_CTRL: rdata_d = {24'h000000, ctrl_b_q[7:6], ovf_q, ctrl_b_q[4:0]}; // RULE_03
				OFF_CAPTURE: rdata_d = {16'h0000, capture_q}; // RULE_18
				OFF_CMP_COMMUT: rdata_d = {16'h0000, cmp_q[0]};
				OFF_CMP_SAMPLE: rdata_d = {16'h0000, cmp_q[1]};
				OFF_CMP_OVFL: rdata_d = {16'h0000, cmp_q[2]};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Checks on the guarded behaviour
	a_pos_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(position_detect_irq_i && ctrl_a_q[POS_RST_EN_BIT]) |=> (count_q == 16'h0000))
		else $error("position event did not clear counter"); // RULE_07
	a_third_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(fire[2] && ctrl_a_q[THIRD_RST_EN_BIT]) |=> (count_q == 16'h0000 && irq_q[2]))
		else $error("third compare did not clear counter"); // RULE_04
	a_ovl_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		($rose(ovl_sync_q[1]) && ctrl_a_q[OVL_RST_EN_BIT]) |=> (count_q == 16'h0000))
		else $error("overload did not clear counter"); // RULE_05
	a_sw_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		sw_rst |=> (count_q == 16'h0000 && ctrl_a_q[SW_RST_BIT] == 1'b0))
		else $error("software restart failed"); // RULE_06
	a_saturate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(count_q == COUNT_MAX && !timer_rst && run && tk.tick) |=> (count_q == COUNT_MAX && ovf_q))
		else $error("counter did not saturate"); // RULE_03
	a_stop_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(!run && !timer_rst) |=> $stable(count_q) && (irq_q == 3'h0))
		else $error("counter moved or fired while disabled"); // RULE_08 RULE_10
	a_disable_disarm: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		($fell(run) && cmp_wr == 3'h0) |=> (armed_q == 3'h0 && irq_q == 3'h0))
		else $error("compare armed after disable"); // RULE_09
	a_one_shot: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(fire[0] && !cmp_wr[0]) |=> !armed_q[0] ##1 !irq_q[0])
		else $error("first compare fired twice"); // RULE_12
	a_rearm_write: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		cmp_wr[1] |=> armed_q[1] && cmp_q[1] == $past(pwdata_i[15:0]))
		else $error("compare write did not re-arm"); // RULE_13
	a_ge_match: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(run && armed_q[0] && count_q >= cmp_q[0]) |=> irq_q[0])
		else $error("magnitude compare missed"); // RULE_11
	a_eq_only: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(irq_q[1]) |-> ($past(count_q) == $past(cmp_q[1])))
		else $error("second compare fired off match"); // RULE_11
	a_capture_pre: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(position_detect_irq_i && ctrl_b_q[POS_CAP_EN_BIT]) |=> (capture_q == $past(count_q)))
		else $error("capture lost pre-restart count"); // RULE_16 RULE_24
	a_ovl_capture: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		($rose(ovl_sync_q[1]) && ctrl_b_q[OVL_CAP_EN_BIT]) |=> (capture_q == $past(count_q)))
		else $error("overload capture missed"); // RULE_15
	a_sw_capture: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		sw_cap |=> (capture_q == $past(count_q)))
		else $error("software capture missed"); // RULE_14 RULE_17
	a_debug_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		(ctrl_b_q[DEBUG_EN_BIT] && |fire) |=> debug_pin_o)
		else $error("debug pin missed interrupt"); // RULE_19

	c_commut_irq: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) irq_q[0]);
	c_third_restart: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		fire[2] && ctrl_a_q[THIRD_RST_EN_BIT]);
	c_overflow: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) $rose(ovf_q));
	c_pos_interval: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		position_detect_irq_i && ctrl_b_q[POS_CAP_EN_BIT] && ctrl_a_q[POS_RST_EN_BIT]);

endmodule : mmtu_top
`default_nettype wire

// File: dv/mmtu_far_model.sv
// Far-side model: position detection logic and overload protection pin.
// Assumes callers enter its tasks just after a rising edge of sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module mmtu_far_model (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	output logic pos_event_o,
	output logic overload_o
);
	// Both lines idle low until an event is requested
	initial begin
		pos_event_o = 1'b0;
		overload_o = 1'b0;
	end

	// A reset drops both lines so no stale event survives it
	always @(posedge sys_rst_i) begin
		pos_event_o <= 1'b0;
		overload_o <= 1'b0;
	end

	// One high cycle is exactly one detection event
	task automatic pos_pulse();
		pos_event_o <= 1'b1;
		@(posedge sys_clk_i);
		pos_event_o <= 1'b0;
	endtask : pos_pulse

	// Pin held high long enough to pass the input synchroniser
	task automatic overload_hit();
		overload_o <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		overload_o <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
	endtask : overload_hit
endmodule : mmtu_far_model
`default_nettype wire

// File: dv/mmtu_tb_top.sv
// Self-checking bench for the mode timer unit, APB master and far-side model.
// Assumes zero or more wait states on APB and the default divide-by-8 clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
	$display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module mmtu_tb_top;
	import mmtu_pkg::*;
	logic sys_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pos_ev;
	logic ovl;
	logic [2:0] irq;
	logic dbg;
	logic dbg_oe;
	logic [7:0] ctrl2 = 8'h00;
	int n_errors = 0;
	int checks_done = 0;
	int n_irq [3];
	int n_dbg = 0;

	// 100 MHz system clock
	always #5 sys_clk_i = ~sys_clk_i;

	mmtu_top mmtu_top_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.position_detect_irq_i(pos_ev), .overload_protect_signal_i(ovl),
		.compare_timer_irq_o(irq), .debug_pin_o(dbg), .debug_pin_oe_o(dbg_oe));

	mmtu_far_model mmtu_far_model_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
		.pos_event_o(pos_ev), .overload_o(ovl));

	// Pulse counters; pulses last one cycle so each high sample is one event
	always @(posedge sys_clk_i) begin
		for (int k = 0; k < 3; k++) begin
			if (irq[k] === 1'b1) n_irq[k]++;
		end
		if (dbg === 1'b1) n_dbg++;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		// No cycle count is assumed; a stuck slave ends through the watchdog
		do begin
			@(posedge sys_clk_i);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_i);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask : rd

	// Whole-register write from a shadow copy, never read-modify-write
	task automatic set_ctrl2(input logic [7:0] v);
		ctrl2 = v;
		wr(OFF_CAP_DBG_CTRL, {24'h0, v});
	endtask : set_ctrl2

	// Running count seen through a software capture
	task automatic get_count(output logic [15:0] c);
		logic [31:0] q;
		wr(OFF_CAP_DBG_CTRL, {24'h0, ctrl2 | 8'h04});
		rd(OFF_CAPTURE, q);
		c = q[15:0];
	endtask : get_count

	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : wait_clk

	task automatic t_regs();
		logic [31:0] q;
		logic e;
		logic [7:0] offs [6];
		offs = '{OFF_CLK_RST_CTRL, OFF_CAP_DBG_CTRL, OFF_CAPTURE, OFF_CMP_COMMUT,
			OFF_CMP_SAMPLE, OFF_CMP_OVFL};
		for (int k = 0; k < 6; k++) begin
			apb(1'b0, offs[k], 32'h0, q, e);
			`CHK("reset value", 32'h0, q)
			`CHK("slverr mapped", 1'b0, e)
		end
		apb(1'b0, 8'h18, 32'h0, q, e);
		`CHK("unmapped slverr", 1'b1, e)
		wr(OFF_CMP_SAMPLE, 32'hFFFF_1234);
		rd(OFF_CMP_SAMPLE, q);
		`CHK("compare readback", 32'h0000_1234, q)
		wr(OFF_CLK_RST_CTRL, 32'h0000_0004);
		rd(OFF_CLK_RST_CTRL, q);
		`CHK("reset strobe reads 0", 32'h0, q)
		wr(OFF_CAP_DBG_CTRL, 32'h0000_0024);
		rd(OFF_CAP_DBG_CTRL, q);
		`CHK("capture strobe reads 0", 32'h0, q)
		$display("test regs done");
	endtask : t_regs

	task automatic t_ge_cmp();
		set_ctrl2(8'h80);
		`CHK("debug oe", 1'b1, dbg_oe)
		wr(OFF_CLK_RST_CTRL, 32'h01);
		wait_clk(80);
		n_irq = '{0, 0, 0};
		n_dbg = 0;
		wr(OFF_CMP_COMMUT, 32'h3);
		wait_clk(10);
		`CHK("late ge fire", 1, n_irq[0])
		`CHK("debug pin pulse", 1, n_dbg)
		wait_clk(40);
		`CHK("one shot", 1, n_irq[0])
		wr(OFF_CMP_COMMUT, 32'h3);
		wait_clk(10);
		`CHK("rearm same value", 2, n_irq[0])
		`CHK("other channels quiet", 0, n_irq[1] + n_irq[2])
		$display("test ge compare done");
	endtask : t_ge_cmp

	task automatic t_eq_cmp();
		logic [15:0] c;
		get_count(c);
		n_irq = '{0, 0, 0};
		wr(OFF_CMP_SAMPLE, {16'h0, c - 16'h2});
		wait_clk(40);
		`CHK("no fire below count", 0, n_irq[1])
		get_count(c);
		wr(OFF_CMP_SAMPLE, {16'h0, c + 16'h4});
		wait_clk(80);
		`CHK("exact match fire", 1, n_irq[1])
		$display("test eq compare done");
	endtask : t_eq_cmp

	task automatic t_disable();
		logic [15:0] c;
		logic [15:0] c2;
		get_count(c);
		n_irq = '{0, 0, 0};
		wr(OFF_CMP_OVFL, {16'h0, c + 16'h4});
		wr(OFF_CLK_RST_CTRL, 32'h00);
		// Count taken once stopped, so ticks before the stop do not matter
		get_count(c);
		wait_clk(100);
		`CHK("no fire disabled", 0, n_irq[2])
		get_count(c2);
		`CHK("count holds", c, c2)
		wr(OFF_CLK_RST_CTRL, 32'h01);
		wait_clk(100);
		`CHK("cancelled compare", 0, n_irq[2])
		$display("test disable done");
	endtask : t_disable

	task automatic t_sw_reset();
		logic [15:0] c1;
		logic [15:0] c2;
		wait_clk(200);
		get_count(c1);
		wr(OFF_CLK_RST_CTRL, 32'h05);
		get_count(c2);
		`CHK("count ran", 1'b1, c1 >= 16'd20)
		`CHK("sw restart", 1'b1, c2 <= 16'd1)
		$display("test sw reset done");
	endtask : t_sw_reset

	task automatic t_position();
		logic [15:0] c;
		logic [31:0] q;
		set_ctrl2(8'h02);
		wr(OFF_CLK_RST_CTRL, 32'h03);
		wait_clk(50);
		mmtu_far_model_i.pos_pulse();
		get_count(c);
		`CHK("pos restart", 1'b1, c <= 16'd1)
		wait_clk(160);
		mmtu_far_model_i.pos_pulse();
		wait_clk(2);
		rd(OFF_CAPTURE, q);
		`CHK("pos interval", 1'b1, (q >= 32'd19 && q <= 32'd22))
		wait_clk(80);
		mmtu_far_model_i.pos_pulse();
		wait_clk(2);
		rd(OFF_CAPTURE, q);
		`CHK("latest capture", 1'b1, (q >= 32'd9 && q <= 32'd11))
		$display("test position done");
	endtask : t_position

	task automatic t_overload();
		logic [31:0] q;
		set_ctrl2(8'h08);
		wr(OFF_CLK_RST_CTRL, 32'h09);
		mmtu_far_model_i.overload_hit();
		wait_clk(152);
		mmtu_far_model_i.overload_hit();
		rd(OFF_CAPTURE, q);
		`CHK("overload interval", 1'b1, (q >= 32'd19 && q <= 32'd21))
		$display("test overload done");
	endtask : t_overload

	task automatic t_third();
		logic [15:0] c;
		set_ctrl2(8'h00);
		wr(OFF_CLK_RST_CTRL, 32'h15);
		n_irq = '{0, 0, 0};
		wr(OFF_CMP_OVFL, 32'h6);
		wait_clk(70);
		`CHK("third fired", 1, n_irq[2])
		get_count(c);
		`CHK("third restart", 1'b1, c < 16'd6)
		$display("test third done");
	endtask : t_third

	task automatic t_clk_sel();
		logic [15:0] c;
		logic [2:0] sels [6];
		int divs [6];
		sels = '{SEL_DIV8, SEL_DIV16, SEL_DIV32, SEL_DIV64, SEL_DIV128, 3'h3};
		divs = '{8, 16, 32, 64, 128, 0};
		for (int k = 0; k < 6; k++) begin
			wr(OFF_CLK_RST_CTRL, {24'h0, sels[k], 5'h00});
			wr(OFF_CLK_RST_CTRL, {24'h0, sels[k], 5'h05});
			wait_clk(divs[k] == 0 ? 256 : 16 * divs[k]);
			get_count(c);
			if (divs[k] == 0) begin
				`CHK("reserved no tick", 16'h0, c)
			end else begin
				`CHK("divided rate", 1'b1, (c >= 16'd15 && c <= 16'd17))
			end
		end
		$display("test clock select done");
	endtask : t_clk_sel

	// Tests run in order after a 16-cycle reset
	initial begin
		n_irq = '{0, 0, 0};
		wait_clk(16);
		sys_rst_i <= 1'b0;
		wait_clk(1);
		t_regs();
		t_ge_cmp();
		t_eq_cmp();
		t_disable();
		t_sw_reset();
		t_position();
		t_overload();
		t_third();
		t_clk_sel();
		test_done();
	end

	// Watchdog, well beyond the roughly 5700 cycles the tests need
	initial begin
		wait_clk(60000);
		n_errors++;
		$display("watchdog expired");
		test_done();
	end
endmodule : mmtu_tb_top
`undef CHK
`default_nettype wire
